/* hdl/acs_cfg.svh */
// constants of the converter serial port: check codes, status layout
// assumes: included by bare name from the design files, not from the package
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// check_scheme_select codes (option_reg_zero, register address 0x7)
`define ACS_OPTION_REG_ZERO_ADDR 4'h7
`define ACS_CHK_OFF 2'h0
`define ACS_CHK_CRC 2'h1
`define ACS_CHK_SUM 2'h2

// check arithmetic
`define ACS_CRC_INIT 8'hFF
`define ACS_CRC_POLY 8'h07
`define ACS_SUM_INIT 8'h00

// status byte: bits [7:5] read as zero
`define ACS_ST_PAD 3'h0

// byte indices of the data phase
`define ACS_IDX_TWO 2'h1
`define ACS_IDX_THREE 2'h2

// synchroniser reset values, order {select_n, sclk, serial_in}
`define ACS_SYNC_RST 3'h4

`endif

/* hdl/acs_pkg.sv */
// types of the converter serial port
// assumes: nothing beyond the tool's package support
`default_nettype none

package acs_pkg;
  typedef enum logic [1:0] {
    ACS_CMD,
    ACS_DATA,
    ACS_CHECK
  } acs_state_t;
endpackage

`default_nettype wire

/* hdl/acs_sync2.sv */
// two-flop synchroniser for the three link pins
// assumes: inputs are asynchronous to ref_clk
`default_nettype none
`include "acs_cfg.svh"

module acs_sync2 (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // pins and their synchronised copies
  input wire logic [2:0] pinIn,
  output logic [2:0] pinSync
);

  localparam logic [2:0] RST_VAL = `ACS_SYNC_RST;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : gBit
      logic stage1_reg;
      logic stage2_reg;
      // first stage feeds only the second
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          stage1_reg <= RST_VAL[i];
          stage2_reg <= RST_VAL[i];
        end else begin
          stage1_reg <= pinIn[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign pinSync[i] = stage2_reg;
    end
  endgenerate

endmodule

`default_nettype wire

/* hdl/acs_check_step.sv */
// one byte step of the selected check: CRC8 or 8-bit sum
// assumes: purely combinational, used once per received or sent byte
`default_nettype none
`include "acs_cfg.svh"

module acs_check_step (
  // running check value and byte
  input wire logic [1:0] scheme,
  input wire logic [7:0] checkIn,
  input wire logic [7:0] dataIn,
  // updated check value
  output logic [7:0] checkOut
);

  logic [7:0] crcWork;

  // xor byte in, then eight shifts
  always_comb begin
    crcWork = checkIn ^ dataIn;
    for (int k = 0; k < 8; k++) begin
      if (crcWork[7]) begin
        crcWork = {crcWork[6:0], 1'b0} ^ `ACS_CRC_POLY;
      end else begin
        crcWork = {crcWork[6:0], 1'b0};
      end
    end
  end

  assign checkOut = (scheme == `ACS_CHK_SUM) ? checkIn + dataIn : crcWork;

endmodule

`default_nettype wire

/* hdl/acs_spi_slave.sv */
// serial slave port of the converter: command, data and check bytes
// assumes: sclk idles low between bytes; register file sits outside and
// answers regRdData combinationally from regAddr
`default_nettype none
`include "acs_cfg.svh"

// How it works
// - deselected: ignore clock, release output pin
// - select tied low still works
// - first byte after select is command
// - sample falling, shift rising, MSB first
// - data phase is two or three bytes
// - after transfer, wait for next command
// - idle pin shows conversion busy flag
// - status byte mirrors fault, tally, busy, range
// - checking only when scheme selects it
// - one check byte after data when checking
// - read check covers command and data
// - bad write check: discard, set fault
// - CRC8 polynomial 0x07, start 0xFF
// - per byte xor then eight shifts
// - check stream starts with command byte
module acs_spi_slave (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link pins
  input wire logic select_n,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out_busy_pin,
  output logic serial_out_busy_pin_en,
  // configuration and status
  input wire logic [1:0] check_scheme_select,
  input wire logic conversion_busy_flag,
  input wire logic [1:0] ready_tally_field,
  input wire logic range_exceeded_flag,
  input wire logic commFaultClear,
  output logic comm_fault_flag,
  // register file
  input wire logic [15:0] wideMap,
  input wire logic [23:0] regRdData,
  output logic [3:0] regAddr,
  output logic regRdStrobe,
  output logic regWrStrobe,
  output logic [23:0] regWrData
);

  // ----------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------
  logic [2:0] pinSync;
  logic selHigh, sclkS, sinS;
  logic sclkPrev_reg;
  logic rise, fall;

  acs_sync2 uSync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn({select_n, sclk, serial_in}),
    .pinSync(pinSync)
  );

  assign selHigh = pinSync[2];
  assign sclkS = pinSync[1];
  assign sinS = pinSync[0];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclkPrev_reg <= 1'b0;
    end else begin
      sclkPrev_reg <= sclkS;
    end
  end

  assign rise = sclkS & ~sclkPrev_reg & ~selHigh;
  assign fall = ~sclkS & sclkPrev_reg & ~selHigh;

  // ----------------------------------------
  // transfer state
  // ----------------------------------------
  acs_pkg::acs_state_t state_reg, state_next;
  logic [2:0] rxCount_reg;
  logic [6:0] rxShift_reg;
  logic [1:0] byteIdx_reg, lastIdx_reg;
  logic rw_reg, checkOn_reg, outActive_reg;
  logic [1:0] scheme_reg;
  logic [7:0] check_reg, txByte_reg;
  logic [6:0] txShift_reg;
  logic [23:0] rdData_reg, wrBuf_reg;
  logic faultSet, commitNow;

  wire [7:0] byteIn = {rxShift_reg, sinS};
  wire byteDone = fall && (rxCount_reg == 3'h7);
  wire inCmd = (state_reg == acs_pkg::ACS_CMD);
  wire inData = (state_reg == acs_pkg::ACS_DATA);
  wire inCheck = (state_reg == acs_pkg::ACS_CHECK);
  wire lastData = (byteIdx_reg == lastIdx_reg);
  wire cmdDone = byteDone && inCmd;
  wire dataDone = byteDone && inData;
  wire checkDone = byteDone && inCheck;
  // transfer ends after last data or check byte
  wire xferEnd = (dataDone && lastData && !checkOn_reg) || checkDone;

  // address in [7:4], direction in [3]
  wire [3:0] cmdAddr = byteIn[7:4];
  wire cmdRead = byteIn[3];

  // command byte opens the check stream
  wire [1:0] stepScheme = inCmd ? check_scheme_select : scheme_reg;
  wire [7:0] stepInit = (check_scheme_select == `ACS_CHK_SUM) ?
    `ACS_SUM_INIT : `ACS_CRC_INIT;
  wire [7:0] stepIn = inCmd ? stepInit : check_reg;
  // read check runs over the bytes sent
  wire [7:0] stepData = (inData && rw_reg) ? txByte_reg : byteIn;
  logic [7:0] stepOut;

  acs_check_step uStep (
    .scheme(stepScheme),
    .checkIn(stepIn),
    .dataIn(stepData),
    .checkOut(stepOut)
  );

  wire [7:0] statusByte = {`ACS_ST_PAD, comm_fault_flag,
    ready_tally_field, conversion_busy_flag, range_exceeded_flag};

  // status during command, then read data or check on reads, zeros on writes
  wire [7:0] loadByte = inCmd ? statusByte :
    !rw_reg ? 8'h00 :
    inData ? rdData_reg[23:16] : check_reg;

  // write commits after the last data byte when not checking, else only on a matching check
  assign commitNow = !rw_reg &&
    ((dataDone && lastData && !checkOn_reg) ||
     (checkDone && byteIn == check_reg));
  assign faultSet = !rw_reg && checkDone && (byteIn != check_reg);
  wire [23:0] wrNext = {wrBuf_reg[15:0], byteIn};

  always_comb begin
    state_next = state_reg;
    if (cmdDone) begin
      state_next = acs_pkg::ACS_DATA;
    end else if (dataDone && lastData) begin
      state_next = checkOn_reg ? acs_pkg::ACS_CHECK : acs_pkg::ACS_CMD;
    end else if (checkDone) begin
      state_next = acs_pkg::ACS_CMD;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= acs_pkg::ACS_CMD;
      rxCount_reg <= 3'h0;
      rxShift_reg <= 7'h00;
    end else if (selHigh) begin
      state_reg <= acs_pkg::ACS_CMD;
      rxCount_reg <= 3'h0;
    end else if (fall) begin
      // sample on falling edge, MSB first
      state_reg <= state_next;
      rxCount_reg <= rxCount_reg + 3'h1;
      rxShift_reg <= byteIn[6:0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rw_reg <= 1'b0;
      checkOn_reg <= 1'b0;
      scheme_reg <= `ACS_CHK_OFF;
      lastIdx_reg <= `ACS_IDX_TWO;
      byteIdx_reg <= 2'h0;
      check_reg <= `ACS_CRC_INIT;
      wrBuf_reg <= 24'h000000;
    end else if (cmdDone) begin
      rw_reg <= cmdRead;
      checkOn_reg <= (check_scheme_select == `ACS_CHK_CRC) ||
        (check_scheme_select == `ACS_CHK_SUM);
      scheme_reg <= check_scheme_select;
      lastIdx_reg <= wideMap[cmdAddr] ? `ACS_IDX_THREE : `ACS_IDX_TWO;
      byteIdx_reg <= 2'h0;
      check_reg <= stepOut;
      wrBuf_reg <= 24'h000000;
    end else if (dataDone) begin
      byteIdx_reg <= byteIdx_reg + 2'h1;
      check_reg <= stepOut;
      wrBuf_reg <= wrNext;
    end
  end

  // ----------------------------------------
  // output shifter and pin drive
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      serial_out_busy_pin <= 1'b0;
      serial_out_busy_pin_en <= 1'b0;
      outActive_reg <= 1'b0;
      txShift_reg <= 7'h00;
      txByte_reg <= 8'h00;
    end else if (selHigh) begin
      serial_out_busy_pin_en <= 1'b0;
      outActive_reg <= 1'b0;
    end else begin
      serial_out_busy_pin_en <= 1'b1;
      if (rise && rxCount_reg == 3'h0) begin
        // update on rising edge, MSB first
        serial_out_busy_pin <= loadByte[7];
        txShift_reg <= loadByte[6:0];
        txByte_reg <= loadByte;
        outActive_reg <= 1'b1;
      end else if (rise) begin
        serial_out_busy_pin <= txShift_reg[6];
        txShift_reg <= {txShift_reg[5:0], 1'b0};
      end else if (xferEnd) begin
        outActive_reg <= 1'b0;
      end else if (!outActive_reg) begin
        serial_out_busy_pin <= conversion_busy_flag;
      end
    end
  end

  // ----------------------------------------
  // register file strobes and fault flag
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regAddr <= 4'h0;
      regRdStrobe <= 1'b0;
      regWrStrobe <= 1'b0;
      regWrData <= 24'h000000;
      rdData_reg <= 24'h000000;
      comm_fault_flag <= 1'b0;
    end else begin
      regRdStrobe <= cmdDone && cmdRead;
      regWrStrobe <= commitNow;
      if (cmdDone) begin
        regAddr <= cmdAddr;
      end
      if (commitNow) begin
        regWrData <= inCheck ? wrBuf_reg : wrNext;
      end
      // read data left aligned, taken while the strobe stands
      if (regRdStrobe) begin
        rdData_reg <= (lastIdx_reg == `ACS_IDX_THREE) ? regRdData :
          {regRdData[15:0], 8'h00};
      end else if (rise && rxCount_reg == 3'h0 && inData) begin
        rdData_reg <= {rdData_reg[15:0], 8'h00};
      end
      if (faultSet) begin
        comm_fault_flag <= 1'b1;
      end else if (commFaultClear) begin
        comm_fault_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  pin_release_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    selHigh |=> !serial_out_busy_pin_en)
    else $error("pin driven while deselected");

  cmd_after_select_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    $fell(selHigh) |-> inCmd && rxCount_reg == 3'h0)
    else $error("select did not restart at command byte");

  fall_sample_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    fall |=> rxCount_reg == $past(rxCount_reg) + 3'h1)
    else $error("falling edge not counted");

  byte_count_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    inData |-> byteIdx_reg <= lastIdx_reg)
    else $error("data phase ran past its byte count");

  idle_busy_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !selHigh && !outActive_reg && !rise && !xferEnd |=>
      serial_out_busy_pin == $past(conversion_busy_flag))
    else $error("idle pin does not show busy flag");

  status_msb_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    rise && inCmd && rxCount_reg == 3'h0 |=> !serial_out_busy_pin
      ##0 txByte_reg == $past(statusByte))
    else $error("status byte not shifted during command");

  check_only_on_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    inCheck |-> checkOn_reg)
    else $error("check byte without checking enabled");

  fault_set_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    faultSet |=> comm_fault_flag && !regWrStrobe)
    else $error("bad check did not flag or discard");

  no_abort_write_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    selHigh |=> !regWrStrobe ##1 !regWrStrobe)
    else $error("write committed after deselect");

  read_fetch_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    cmdDone && cmdRead |=> regRdStrobe && regAddr == $past(cmdAddr))
    else $error("read command did not fetch register");

endmodule

`default_nettype wire

/* bench/acs_host_model.sv */
// host model: master side of the converter serial port
// assumes: ref_clk is the bench clock; sclk half period is 8 ref_clk
`default_nettype none

module acs_host_model (
  // clock
  input wire logic ref_clk,
  // link pins
  output logic select_n,
  output logic sclk,
  output logic serial_in,
  input wire logic pinData,
  input wire logic pinEn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic frameOn;

  initial begin
    select_n = 1'h1;
    sclk = 1'h0;
    serial_in = 1'h0;
    frameOn = 1'h0;
  end

  // released data line toggles so no stale bit can pass
  always @(posedge ref_clk) begin
    if (!frameOn) serial_in <= ~serial_in;
  end

  // pin as the host sees it, inverted when released so stale bits fail
  function automatic logic seen();
    return pinEn ? pinData : ~pinData;
  endfunction

  // select with no clock, returns the idle pin
  task automatic look(output logic v);
    @(posedge ref_clk);
    select_n <= 1'h0;
    repeat (8) @(posedge ref_clk);
    v = seen();
    select_n <= 1'h1;
  endtask

  // command first, msb first, shift on rise
  task automatic xfer(input int n, input logic [63:0] tx,
                      output logic [63:0] rx);
    rx = '0;
    @(posedge ref_clk);
    frameOn <= 1'h1;
    select_n <= 1'h0;
    repeat (4) @(posedge ref_clk);
    for (int i = n * 8 - 1; i >= 0; i--) begin
      sclk <= 1'h1;
      serial_in <= tx[i];
      repeat (8) @(posedge ref_clk);
      rx[i] = seen();
      sclk <= 1'h0;
      repeat (8) @(posedge ref_clk);
    end
    select_n <= 1'h1;
    frameOn <= 1'h0;
  endtask
endmodule

`default_nettype wire

/* bench/adc_spi_slave_with_crc_tb.sv */
// testbench of the converter serial port driven by the host model
// assumes: register file answers from regAddr; only ref_clk is generated
`default_nettype none

module adc_spi_slave_with_crc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, select_n, sclk, serial_in, pin, pinEn, v;
  logic busy, range, faultClr, fault, rdStb, wrStb;
  logic [1:0] scheme, tally;
  logic [3:0] regAddr, rdAddr;
  logic [15:0] wideMap;
  logic [23:0] rdData, wrData, lastWr;
  logic [63:0] rx;
  int errors = 0;
  int nChecks = 0;
  int nWr = 0;

  acs_spi_slave uut (.ref_clk(ref_clk), .reset(reset),
    .select_n(select_n), .sclk(sclk), .serial_in(serial_in),
    .serial_out_busy_pin(pin), .serial_out_busy_pin_en(pinEn),
    .check_scheme_select(scheme), .conversion_busy_flag(busy),
    .ready_tally_field(tally), .range_exceeded_flag(range),
    .commFaultClear(faultClr), .comm_fault_flag(fault),
    .wideMap(wideMap), .regRdData(rdData), .regAddr(regAddr),
    .regRdStrobe(rdStb), .regWrStrobe(wrStb), .regWrData(wrData));

  acs_host_model host (.ref_clk(ref_clk), .select_n(select_n),
    .sclk(sclk), .serial_in(serial_in), .pinData(pin), .pinEn(pinEn));

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [23:0] rdv(input logic [3:0] a);
    return {a, 4'h5, a, 4'hC, a, 4'h3};
  endfunction
  assign rdData = rdv(regAddr);

  always @(posedge ref_clk) begin
    if (rdStb === 1'h1) rdAddr <= regAddr;
    if (wrStb === 1'h1) begin
      nWr <= nWr + 1;
      lastWr <= wrData;
    end
  end

  // ---------------------------------------------------------------
  // expected check byte and comparison
  // ---------------------------------------------------------------
  function automatic logic [7:0] chk(input logic [31:0] d, input int nb);
    logic [7:0] c;
    c = (scheme == 2'h1) ? 8'hFF : 8'h00;
    for (int i = nb - 1; i >= 0; i--) begin
      if (scheme == 2'h2) c = c + d[i * 8 +: 8];
      else begin
        c = c ^ d[i * 8 +: 8];
        for (int k = 0; k < 8; k++) c = {c[6:0], 1'h0} ^ (c[7] ? 8'h07 : 8'h00);
      end
    end
    return c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // register access over the link
  // ---------------------------------------------------------------
  task automatic rdReg(input logic [3:0] a, input logic [7:0] st);
    int n, on;
    logic [23:0] d, m;
    logic [31:0] cd;
    n = wideMap[a] ? 3 : 2;
    on = (scheme == 2'h1 || scheme == 2'h2) ? 1 : 0;
    m = (n == 3) ? 24'hFFFFFF : 24'h00FFFF;
    d = rdv(a) & m;
    cd = ({24'h0, a, 4'h8} << (8 * n)) | {8'h0, d};
    host.xfer(1 + n + on, {56'h0, a, 4'h8} << (8 * (n + on)), rx);
    check(rx[8 * (n + on) +: 8], st);
    check(rx[8 * on +: 24] & m, d);
    if (on) check(rx[7:0], chk(cd, n + 1));
    check(rdAddr, a);
  endtask

  task automatic wrReg(input logic [3:0] a, input logic [23:0] d,
                       input logic [7:0] bad, input int cut, input int ok);
    int n, on, nb, w0;
    logic [31:0] cd;
    logic [39:0] tx;
    n = wideMap[a] ? 3 : 2;
    on = (scheme == 2'h1 || scheme == 2'h2) ? 1 : 0;
    nb = cut ? cut : 1 + n + on;
    cd = ({24'h0, a, 4'h0} << (8 * n)) | {8'h0, d};
    tx = on ? {cd, chk(cd, n + 1) ^ bad} : {8'h0, cd};
    w0 = nWr;
    host.xfer(nb, {24'h0, tx} >> (8 * (1 + n + on - nb)), rx);
    check(32'(nWr - w0), ok);
    if (ok) check(lastWr, d);
  endtask

  initial begin
    repeat (80000) @(posedge ref_clk);
    errors++;
    test_done();
  end

  initial begin
    reset = 1'h1;
    scheme = 2'h0;
    tally = 2'h2;
    busy = 1'h1;
    range = 1'h1;
    faultClr = 1'h0;
    wideMap = 16'h00F0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (4) @(posedge ref_clk);
    check(pinEn, 1'h0);
    for (int b = 0; b < 2; b++) begin
      busy <= b[0];
      host.look(v);
      check(v, b[0]);
    end
    busy <= 1'h1;
    for (int s = 0; s < 4; s++) begin
      scheme <= s[1:0];
      @(posedge ref_clk);
      rdReg(4'h2, 8'h0B);
      rdReg(4'h5, 8'h0B);
    end
    for (int s = 0; s < 3; s++) begin
      scheme <= s[1:0];
      @(posedge ref_clk);
      wrReg(4'h2, 24'h1012, 8'h00, 0, 1);
      wrReg(4'h6, 24'hABCDEF, 8'h00, 0, 1);
      if (s > 0) begin
        wrReg(4'h2, 24'h1012, 8'h01, 0, 0);
        check(fault, 1'h1);
        rdReg(4'h3, 8'h1B);
        faultClr <= 1'h1;
        @(posedge ref_clk);
        faultClr <= 1'h0;
        repeat (2) @(posedge ref_clk);
        check(fault, 1'h0);
      end
    end
    scheme <= 2'h0;
    @(posedge ref_clk);
    wrReg(4'h2, 24'h0BAD, 8'h00, 2, 0);
    rdReg(4'h2, 8'h0B);
    host.xfer(6, {16'h0, 8'h28, 16'h0, 8'h38, 16'h0}, rx);
    check(rx[39:24], rdv(4'h2) & 24'h00FFFF);
    check(rx[23:16], 8'h0B);
    check(rx[15:0], rdv(4'h3) & 24'h00FFFF);
    repeat (6) @(posedge ref_clk);
    check(pinEn, 1'h0);
    test_done();
  end
endmodule

`default_nettype wire
